// >>> spcs_params.svh
`ifndef SPCS_PARAMS_SVH
`define SPCS_PARAMS_SVH

// ==========================================
// reset values of bus line levels
`define SPCS_CS_RESET_LEVEL 1'b0
`define SPCS_CLK_RESET_LEVEL 1'b0
// shift register width
`define SPCS_WORD_BITS 8
// slave shift counter width
`define SPCS_CNT_BITS 4

`endif

// >>> spcs_pkg.sv
`include "spcs_params.svh"

package spcs_pkg;
    // ==========================================
    // master bring-up phase of the polarity latch
    typedef enum logic [1:0] {
        SPCS_POL_RESET,
        SPCS_POL_FORCED,
        SPCS_POL_APPLIED
    } spcs_pol_t;
endpackage : spcs_pkg

// >>> spcs_core.sv
`timescale 1ns/1ps
`include "spcs_params.svh"

// Contract
// - master applies polarity on first channel enable
// - changed cs polarity gives rising cs edge
// - slave loads shifter on cs transition
// - load without data flags underflow when channel enabled; interrupt when irq enabled
// - no underflow while slave cs input level unchanged
// - force pulse under single applies polarity
module spcs_core
    import spcs_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic master_mode,
    input wire logic single_mode,
    input wire logic force_cs,
    input wire logic cs_inactive_high,
    input wire logic clk_idle_high,
    input wire logic chan_enable,
    input wire logic tx_valid,
    input wire logic [`SPCS_WORD_BITS-1:0] tx_data,
    input wire logic underflow_clear,
    input wire logic underflow_irq_en,
    input wire logic cs_in,
    input wire logic sclk_in,
    input wire logic mosi_in,
    output logic tx_taken,
    output logic cs_out,
    output logic cs_oe,
    output logic sclk_out,
    output logic sclk_oe,
    output logic miso_out,
    output logic miso_oe,
    output logic underflow_flag,
    output logic underflow_irq,
    output logic [`SPCS_WORD_BITS-1:0] rx_data
);

    // ==========================================
    // state
    typedef struct packed {
        spcs_pol_t pol;                          // master polarity phase
        logic cs_pol;                            // applied cs idle level
        logic clk_pol;                           // applied clock idle level
        logic [2:0] cs_sync;                     // cs pin sync plus history
        logic [2:0] sclk_sync;                   // sclk pin sync plus history
        logic [1:0] mosi_sync;                   // mosi pin sync
        logic [`SPCS_WORD_BITS-1:0] shift;       // slave shifter
        logic [`SPCS_CNT_BITS-1:0] cnt;          // bits shifted
        logic [`SPCS_WORD_BITS-1:0] rx;          // received word
        logic uflow;                             // sticky underflow
    } spcs_state_t;

    spcs_state_t st_reg;  // registered state
    spcs_state_t st_next; // next state
    logic cs_edge;        // slave cs transition seen
    logic sclk_rise;      // slave sampling edge
    logic load_ok;        // slave load succeeds

    // count value of the final bit of a word
    localparam logic [`SPCS_CNT_BITS-1:0] spcs_last_bit = (`SPCS_CNT_BITS)'(`SPCS_WORD_BITS - 1);

    // ==========================================
    // shifter value after one sampled bit, msb first
    function automatic logic [`SPCS_WORD_BITS-1:0] spcs_shift_in(
        input logic [`SPCS_WORD_BITS-1:0] word,
        input logic bit_in
    );
        return {word[`SPCS_WORD_BITS-2:0], bit_in};
    endfunction : spcs_shift_in

    // ==========================================
    // next state
    always_comb
    begin
        st_next = st_reg;
        st_next.cs_sync = {st_reg.cs_sync[1:0], cs_in};
        st_next.sclk_sync = {st_reg.sclk_sync[1:0], sclk_in};
        st_next.mosi_sync = {st_reg.mosi_sync[0], mosi_in};
        // edges use synchronised stages only
        cs_edge = ~master_mode && (st_reg.cs_sync[2] != st_reg.cs_sync[1]);
        sclk_rise = ~master_mode && ~st_reg.sclk_sync[2] && st_reg.sclk_sync[1];
        load_ok = cs_edge && tx_valid;
        // pulse only on a running cycle, so a frozen edge is not taken twice
        tx_taken = load_ok && clk_en;
        // master polarity latch
        case (st_reg.pol)
            SPCS_POL_RESET:
            begin
                if (master_mode && chan_enable)
                begin
                    st_next.pol = SPCS_POL_APPLIED;
                end
                else if (master_mode && single_mode && force_cs)
                begin
                    // force set under single mode arms early apply
                    st_next.pol = SPCS_POL_FORCED;
                end
            end
            SPCS_POL_FORCED:
            begin
                if (chan_enable || !force_cs)
                begin
                    st_next.pol = SPCS_POL_APPLIED;
                end
            end
            default:
            begin
                st_next.pol = SPCS_POL_APPLIED;
            end
        endcase
        if (st_next.pol == SPCS_POL_APPLIED)
        begin
            // polarity tracks config once applied; rising cs edge if changed
            st_next.cs_pol = cs_inactive_high;
            st_next.clk_pol = clk_idle_high;
        end
        // slave: cs transition loads shifter
        if (cs_edge)
        begin
            st_next.cnt = '0;
            if (tx_valid)
            begin
                st_next.shift = tx_data;
            end
        end
        else if (sclk_rise)
        begin
            st_next.shift = spcs_shift_in(st_reg.shift, st_reg.mosi_sync[1]);
            st_next.cnt = st_reg.cnt + 1'b1;
            // last bit of the word completes the received value
            if (st_reg.cnt == spcs_last_bit)
            begin
                st_next.rx = spcs_shift_in(st_reg.shift, st_reg.mosi_sync[1]);
            end
        end
        // sticky underflow; set beats clear
        if (underflow_clear)
        begin
            st_next.uflow = 1'b0;
        end
        if (cs_edge && !tx_valid && chan_enable)
        begin
            st_next.uflow = 1'b1;
        end
    end

    // ==========================================
    // registers
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            st_reg <= '{pol: SPCS_POL_RESET, cs_pol: `SPCS_CS_RESET_LEVEL,
                        clk_pol: `SPCS_CLK_RESET_LEVEL, default: '0};
        end
        else if (clk_en)
        begin
            st_reg <= st_next;
        end
    end

    // ==========================================
    // outputs
    assign cs_out = st_reg.cs_pol;              // idle cs level
    assign cs_oe = master_mode;
    assign sclk_out = st_reg.clk_pol;           // idle clock level
    assign sclk_oe = master_mode;
    assign miso_out = st_reg.shift[`SPCS_WORD_BITS-1];
    assign miso_oe = ~master_mode;
    assign underflow_flag = st_reg.uflow;
    assign underflow_irq = st_reg.uflow & underflow_irq_en;
    assign rx_data = st_reg.rx;

    // ==========================================
    // checks
    a_pol_held_reset: assert property (@(posedge clk) disable iff (reset)
        (st_reg.pol == SPCS_POL_RESET) |-> (cs_out == `SPCS_CS_RESET_LEVEL))
        else $error("cs left reset level before enable");
    a_pol_rising_cs: assert property (@(posedge clk) disable iff (reset)
        (clk_en && st_reg.pol == SPCS_POL_RESET && master_mode && chan_enable && cs_inactive_high)
        |=> cs_out)
        else $error("no cs rise on first enable");
    a_load_on_edge: assert property (@(posedge clk) disable iff (reset)
        (clk_en && cs_edge && tx_valid) |=> (st_reg.shift == $past(tx_data)))
        else $error("shifter not loaded on cs edge");
    a_uflow_set: assert property (@(posedge clk) disable iff (reset)
        (clk_en && cs_edge && !tx_valid && chan_enable) |=> underflow_flag)
        else $error("underflow not flagged");
    a_uflow_cause: assert property (@(posedge clk) disable iff (reset)
        $rose(underflow_flag) |-> $past(cs_edge && !tx_valid))
        else $error("underflow without cause");
    a_force_apply: assert property (@(posedge clk) disable iff (reset)
        (clk_en && st_reg.pol == SPCS_POL_FORCED && !force_cs) |=> (st_reg.pol == SPCS_POL_APPLIED))
        else $error("force pulse did not apply polarity");
    a_uflow_sticky: assert property (@(posedge clk) disable iff (reset)
        (underflow_flag && !underflow_clear) |=> underflow_flag)
        else $error("underflow dropped without clear");
    a_irq_gate: assert property (@(posedge clk) disable iff (reset)
        underflow_irq |-> (underflow_flag && underflow_irq_en))
        else $error("interrupt not gated");
    a_clk_held_reset: assert property (@(posedge clk) disable iff (reset)
        (st_reg.pol == SPCS_POL_RESET) |-> (sclk_out == `SPCS_CLK_RESET_LEVEL))
        else $error("clock left reset level before enable");
    a_uflow_clear: assert property (@(posedge clk) disable iff (reset)
        (clk_en && underflow_clear && !(cs_edge && !tx_valid && chan_enable))
        |=> !underflow_flag)
        else $error("underflow not cleared");
    a_uflow_needs_en: assert property (@(posedge clk) disable iff (reset)
        (clk_en && cs_edge && !chan_enable && !underflow_flag)
        |=> !underflow_flag)
        else $error("underflow with channel disabled");
    // a low enable must hold every bit of state
    a_state_frozen: assert property (@(posedge clk) disable iff (reset)
        !clk_en |=> (st_reg == $past(st_reg)))
        else $error("state moved while frozen");

endmodule : spcs_core

// >>> spcs_peer.sv
`timescale 1ns/1ps
// ========================================
// slave peer: counts cs line edges it sees
module spcs_peer
(
    input wire logic clk,
    input wire logic cs,
    output int edges
);
    logic last = 1'b0; // cs level at last edge
    int count = 0;     // edges seen so far
    assign edges = count;
    // sample the line as a slave would
    always @(posedge clk)
    begin
        if (cs !== last)
        begin
            count <= count + 1;
        end
        last <= cs;
    end
endmodule : spcs_peer

// >>> spi_cs_polarity_underflow_bench.sv
`timescale 1ns/1ps
// ========================================
// bench for the cs polarity start-up block
module spi_cs_polarity_underflow_bench
    import spcs_pkg::*;
;
    logic clk, reset, en, mm, sm, fc, cph, kph, ce, tv, uc, ie, csi, sci, mi;
    logic [7:0] td;
    logic taken, cso, sco, uf, irq;
    logic cs_oe_w, sclk_oe_w, miso_w, miso_oe_w; // enables and slave data line
    logic seen = 1'b0; // shifter load observed
    logic [7:0] rx;
    logic [7:0] b = 8'hA5; // word shifted in
    int miscompares = 0;
    int checked = 0;
    int edges, n;
    spcs_core DUT (.clk(clk), .reset(reset), .clk_en(en), .master_mode(mm), .single_mode(sm),
        .force_cs(fc), .cs_inactive_high(cph), .clk_idle_high(kph), .chan_enable(ce), .tx_valid(tv),
        .tx_data(td), .underflow_clear(uc), .underflow_irq_en(ie), .cs_in(csi), .sclk_in(sci),
        .mosi_in(mi), .tx_taken(taken), .cs_out(cso), .cs_oe(cs_oe_w), .sclk_out(sco), .sclk_oe(sclk_oe_w),
        .miso_out(miso_w), .miso_oe(miso_oe_w), .underflow_flag(uf), .underflow_irq(irq), .rx_data(rx));
    spcs_peer peer (.clk(clk), .cs(cso), .edges(edges));
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // remember any load of the shifter
    always @(posedge clk)
    begin
        if (taken === 1'b1) seen <= 1'b1;
    end
    task cyc(input int k);
        repeat (k) @(posedge clk);
        #2;
    endtask : cyc
    task chk(input logic [7:0] g, input logic [7:0] e);
        checked++;
        if (g !== e)
        begin
            miscompares++;
            $display("ERROR %0t got %h want %h", $time, g, e);
        end
    endtask : chk
    task rst;
        reset = 1'b1;
        cyc(5);
        reset = 1'b0;
        cyc(1);
    endtask : rst
    task report_and_stop;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : report_and_stop
    // watchdog
    initial
    begin
        #20000;
        miscompares++;
        report_and_stop;
    end
    // ========================================
    // main sequence
    initial
    begin
        {mm, sm, fc, cph, kph, ce, tv, uc, ie, csi, sci, mi} = '0;
        en = 1'b1;
        td = 8'hC3;
        rst;
        // polarity left at reset: enable gives no cs edge
        mm = 1'b1;
        n = edges;
        ce = 1'b1;
        cyc(2);
        chk(8'(edges - n), 8'h00);
        chk(cso, 8'h00);
        ce = 1'b0;
        rst;
        // changed polarity waits for the first enable
        cph = 1'b1;
        kph = 1'b1;
        cyc(4);
        chk(cso, 8'h00);
        chk(sco, 8'h00);
        chk(cs_oe_w, 8'h01);
        chk(sclk_oe_w, 8'h01);
        n = edges;
        ce = 1'b1;
        cyc(1);
        chk(cso, 8'h01);
        chk(sco, 8'h01);
        // peer sees the new level one edge later
        cyc(1);
        chk(8'(edges - n), 8'h01);
        // force outside single mode is ignored
        ce = 1'b0;
        rst;
        fc = 1'b1;
        cyc(1);
        fc = 1'b0;
        cyc(2);
        chk(cso, 8'h00);
        // early polarity update, one step per access
        sm = 1'b1;
        cyc(1);
        fc = 1'b1;
        cyc(1);
        fc = 1'b0;
        cyc(1);
        sm = 1'b0;
        cyc(1);
        chk(cso, 8'h01);
        chk(sco, 8'h01);
        // slave side, channel off then on
        mm = 1'b0;
        rst;
        chk(miso_oe_w, 8'h01);
        csi = 1'b1;
        cyc(6);
        chk(uf, 8'h00);
        ce = 1'b1;
        csi = 1'b0;
        cyc(6);
        chk(uf, 8'h01);
        chk(irq, 8'h00);
        ie = 1'b1;
        cyc(8);
        chk(irq, 8'h01);
        uc = 1'b1;
        cyc(1);
        uc = 1'b0;
        cyc(1);
        chk(uf, 8'h00);
        tv = 1'b1;
        csi = 1'b1;
        cyc(6);
        chk(uf, 8'h00);
        chk(seen, 8'h01);
        chk(miso_w, 8'h01);
        tv = 1'b0;
        cyc(6);
        chk(uf, 8'h00);
        // word in at link rate, msb first
        for (int i = 7; i >= 0; i--)
        begin
            mi = b[i];
            cyc(4);
            sci = 1'b1;
            cyc(4);
            sci = 1'b0;
        end
        cyc(4);
        chk(rx, 8'hA5);
        report_and_stop;
    end
endmodule : spi_cs_polarity_underflow_bench
